// [inc/pldc_consts.vh]
// Purpose: constants for the synthesizer divider and lock-pin configuration block
// Assumes: 32-bit AXI4-Lite register words, byte addresses
// Notes:   offsets are local choices; field positions follow the register layout below
`ifndef PLDC_CONSTS_VH
`define PLDC_CONSTS_VH

`define PLDC_OFF_REFCTL      4'h0
`define PLDC_OFF_FBCTL       4'h4
`define PLDC_OFF_STATUS      4'h8
`define PLDC_OFF_PLANT       4'hC

// ref_divider_and_output_control fields
`define PLDC_REF_LSB         0
`define PLDC_REF_MSB         11
`define PLDC_SEL_LSB         12
`define PLDC_SEL_MSB         15
`define PLDC_SLEEP_BIT       16
`define PLDC_GATE_BIT        17
`define PLDC_TAP_BIT         18

// feedback_divider_control fields
`define PLDC_FB_LSB          0
`define PLDC_FB_MSB          17
`define PLDC_POST_LSB        18
`define PLDC_POST_MSB        21

`define PLDC_RST_REF         12'h00_0A
`define PLDC_RST_FB          18'h0_02F8
`define PLDC_RST_POST        4'h2
`define PLDC_RST_SEL         4'h0

`define PLDC_SEL_HIZ         4'h0
`define PLDC_SEL_HIGH        4'h1
`define PLDC_SEL_LOW         4'h2
`define PLDC_SEL_LOCK_H      4'h3
`define PLDC_SEL_LOCK_L      4'h4
`define PLDC_SEL_FB_HALF     4'h9
`define PLDC_SEL_REF_HALF    4'hB

`define PLDC_CAL_CYCLES      8'h40

`endif

// [rtl/pldc_div_half.v]
// Purpose: programmable integer divider with a halved 50% duty output
// Assumes: ratio code zero never loaded; run held low while idle, which clears count and pulse but keeps half
// Notes:   pulse marks the divided event, half toggles on each pulse
module pldc_div_half
(
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        run,
    input  wire        tick,
    input  wire [17:0] ratio,
    output reg         pulse,
    output reg         half
);
    reg [17:0] count_reg;

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            count_reg <= 18'h0_0000;
            pulse     <= 1'b0;
            half      <= 1'b0;
        end
        else if (!run)
        begin
            count_reg <= 18'h0_0000;
            pulse     <= 1'b0;
        end
        else
        begin
            pulse <= 1'b0;
            if (tick)
            begin
                if (count_reg + 18'h0_0001 >= ratio)
                begin
                    count_reg <= 18'h0_0000;
                    pulse     <= 1'b1;
                    half      <= ~half;
                end
                else
                    count_reg <= count_reg + 18'h0_0001;
            end
        end
    end
endmodule

// [rtl/pldc_top.v]
// Purpose: AXI4-Lite configuration of reference, feedback and post dividers plus lock pin control
// Assumes: oscTick/vcoTick are one-cycle strobes of the input and VCO clocks, synchronous to clk_sys
// Notes:   divider model is a digital stand-in for the analog loop
//
// Contract
// - reference divider is a 12-bit ratio code, reset 10, zero invalid
// - every feedback register write starts frequency calibration; a write while the sleep bit is set leaves the sequencer idle
// - selector 0 high impedance (reset), 1 drives high, 2 drives low
// - selector 3 lock result active high, 4 active low
// - selector 9 feedback divider halved, 11 reference divider halved
// - sleep bit set shuts down everything; resets to 0
// - gate 0 disables all clock outputs; resets to 1 (code gates clockOutputsOn and distClkTick only, not vcoTapOut)
// - vco tap enable drives raw vco pin; resets to 0
// - feedback divider is 18-bit ratio code, reset 760, zero invalid
// - feedback divider fed by post divider output; total ratio is product
// - vco frequency equals osc times feedback times post over reference
// - post divider code 2..8 equals ratio; reset 2
// - post divider always between vco and distribution, never bypassed
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`include "pldc_consts.vh"
module pldc_top
(
    input  wire        clk_sys,
    input  wire        rst,
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        oscTick,
    input  wire        vcoTick,
    input  wire        lockDetect,
    input  wire        outputsGatePin,
    output reg         lockPinOut,
    output reg         lockPinOe_n,
    output reg         vcoTapOut,
    output reg         distClkTick,
    output reg         clockOutputsOn,
    output reg         chipAwake,
    output reg         calBusy
);
    localparam ST_IDLE = 3'b001;
    localparam ST_CAL  = 3'b010;
    localparam ST_RUN  = 3'b100;

    reg [11:0] refDiv_reg;
    reg [3:0]  lockSel_reg;
    reg        sleep_reg;
    reg        gate_reg;
    reg        tapEn_reg;
    reg [17:0] fbDiv_reg;
    reg [3:0]  postDiv_reg;
    reg [2:0]  state_reg;
    reg [7:0]  calCnt_reg;
    reg [3:0]  awAddr_reg;
    reg [31:0] wData_reg;
    reg [3:0]  wStrb_reg;
    reg        awHave_reg;
    reg        wHave_reg;
    reg        lockSeen_reg;
    reg        lockPin_next;
    reg        lockOe_next;

    wire       refPulse;
    wire       refHalf;
    wire       postPulse;
    wire       fbPulse;
    wire       fbHalf;
    wire       divRun = !sleep_reg && (state_reg != ST_IDLE);
    wire       wrFire = awHave_reg && wHave_reg && !s_axi_bvalid;
    wire       fbWrite = wrFire && (awAddr_reg == `PLDC_OFF_FBCTL);

    function [31:0] mergeBytes;
        input [31:0] oldVal;
        input [31:0] newVal;
        input [3:0]  strb;
        integer      i;
        begin
            mergeBytes = oldVal;
            for (i = 0; i < 4; i = i + 1)
                if (strb[i])
                    mergeBytes[i*8 +: 8] = newVal[i*8 +: 8];
        end
    endfunction

    // merged words are built outside the clocked write so that process stays purely non-blocking
    wire [31:0] refMerge = mergeBytes({13'h0000, tapEn_reg, gate_reg, sleep_reg, lockSel_reg, refDiv_reg},
                                      wData_reg, wStrb_reg);
    wire [31:0] fbMerge  = mergeBytes({10'h000, postDiv_reg, fbDiv_reg}, wData_reg, wStrb_reg);

    // reference divider counts the input oscillator
    pldc_div_half u_refDiv
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .run     (divRun),
        .tick    (oscTick),
        .ratio   ({6'h00, refDiv_reg}),
        .pulse   (refPulse),
        .half    (refHalf)
    );

    // post divider sits on the vco with no bypass path
    pldc_div_half u_postDiv
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .run     (divRun),
        .tick    (vcoTick),
        .ratio   ({14'h0000, postDiv_reg}),
        .pulse   (postPulse),
        .half    ()
    );

    // feedback divider counts post divider output, so total ratio is the product
    pldc_div_half u_fbDiv
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .run     (divRun),
        .tick    (postPulse),
        .ratio   (fbDiv_reg),
        .pulse   (fbPulse),
        .half    (fbHalf)
    );

    // write channel: address and data accepted in either order
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
            awHave_reg    <= 1'b0;
            wHave_reg     <= 1'b0;
            awAddr_reg    <= 4'h0;
            wData_reg     <= 32'h0000_0000;
            wStrb_reg     <= 4'h0;
            refDiv_reg    <= `PLDC_RST_REF;
            lockSel_reg   <= `PLDC_RST_SEL;
            sleep_reg     <= 1'b0;
            gate_reg      <= 1'b1;
            tapEn_reg     <= 1'b0;
            fbDiv_reg     <= `PLDC_RST_FB;
            postDiv_reg   <= `PLDC_RST_POST;
        end
        else
        begin
            s_axi_awready <= !awHave_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !wHave_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHave_reg <= 1'b1;
                awAddr_reg <= {s_axi_awaddr[3:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHave_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end
            if (wrFire)
            begin
                awHave_reg   <= 1'b0;
                wHave_reg    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= 2'b00;
                case (awAddr_reg)
                    `PLDC_OFF_REFCTL:
                    begin
                        refDiv_reg  <= refMerge[`PLDC_REF_MSB:`PLDC_REF_LSB];
                        lockSel_reg <= refMerge[`PLDC_SEL_MSB:`PLDC_SEL_LSB];
                        sleep_reg   <= refMerge[`PLDC_SLEEP_BIT];
                        gate_reg    <= refMerge[`PLDC_GATE_BIT];
                        tapEn_reg   <= refMerge[`PLDC_TAP_BIT];
                    end
                    `PLDC_OFF_FBCTL:
                    begin
                        fbDiv_reg   <= fbMerge[`PLDC_FB_MSB:`PLDC_FB_LSB];
                        postDiv_reg <= fbMerge[`PLDC_POST_MSB:`PLDC_POST_LSB];
                    end
                    `PLDC_OFF_STATUS:
                        s_axi_bresp <= 2'b10;
                    default:
                        s_axi_bresp <= 2'b10;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // read channel: both config words, status, unmapped answers slverr
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'b00;
        end
        else
        begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'b00;
                case ({s_axi_araddr[3:2], 2'b00})
                    `PLDC_OFF_REFCTL:
                        s_axi_rdata <= {13'h0000, tapEn_reg, gate_reg, sleep_reg, lockSel_reg, refDiv_reg};
                    `PLDC_OFF_FBCTL:
                        s_axi_rdata <= {10'h000, postDiv_reg, fbDiv_reg};
                    `PLDC_OFF_STATUS:
                        s_axi_rdata <= {28'h000_0000, lockSeen_reg, calBusy, state_reg == ST_RUN, chipAwake};
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // calibration sequencer; a new feedback write restarts it even mid-run
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_reg  <= ST_IDLE;
            calCnt_reg <= 8'h00;
        end
        else if (sleep_reg)
        begin
            state_reg  <= ST_IDLE;
            calCnt_reg <= 8'h00;
        end
        else if (fbWrite)
        begin
            state_reg  <= ST_CAL;
            calCnt_reg <= `PLDC_CAL_CYCLES;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                    state_reg <= ST_IDLE;
                ST_CAL:
                begin
                    if (calCnt_reg == 8'h01)
                        state_reg <= ST_RUN;
                    calCnt_reg <= calCnt_reg - 8'h01;
                end
                ST_RUN:
                    state_reg <= ST_RUN;
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // lock pin selection; reserved codes fall back to high impedance
    always @*
    begin
        lockPin_next = 1'b0;
        lockOe_next  = 1'b0;
        case (lockSel_reg)
            `PLDC_SEL_HIZ:      lockOe_next = 1'b1;
            `PLDC_SEL_HIGH:     lockPin_next = 1'b1;
            `PLDC_SEL_LOW:      lockPin_next = 1'b0;
            `PLDC_SEL_LOCK_H:   lockPin_next = lockSeen_reg;
            `PLDC_SEL_LOCK_L:   lockPin_next = !lockSeen_reg;
            `PLDC_SEL_FB_HALF:  lockPin_next = fbHalf;
            `PLDC_SEL_REF_HALF: lockPin_next = refHalf;
            default:            lockOe_next = 1'b1;
        endcase
        if (sleep_reg)
        begin
            lockPin_next = 1'b0;
            lockOe_next  = 1'b1;
        end
    end

    // registered outputs
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            lockSeen_reg   <= 1'b0;
            lockPinOut     <= 1'b0;
            lockPinOe_n    <= 1'b1;
            vcoTapOut      <= 1'b0;
            distClkTick    <= 1'b0;
            clockOutputsOn <= 1'b0;
            chipAwake      <= 1'b0;
            calBusy        <= 1'b0;
        end
        else
        begin
            lockSeen_reg   <= lockDetect && (state_reg == ST_RUN) && !sleep_reg;
            lockPinOut     <= lockPin_next;
            lockPinOe_n    <= lockOe_next;
            vcoTapOut      <= tapEn_reg && !sleep_reg && vcoTick;
            distClkTick    <= postPulse && gate_reg && outputsGatePin && !sleep_reg;
            clockOutputsOn <= gate_reg && outputsGatePin && !sleep_reg;
            chipAwake      <= !sleep_reg;
            calBusy        <= (state_reg == ST_CAL);
        end
    end
endmodule

// [dv/pldc_top_properties.sv]
// Purpose: checker for pldc_top pins and calibration
// Assumes: full-word register writes
// Notes: keeps its own selector copy since registers are hidden
module pldc_props
(
    input wire        clk_sys,
    input wire        rst,
    input wire [3:0]  s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        oscTick,
    input wire        vcoTick,
    input wire        lockDetect,
    input wire        outputsGatePin,
    input wire        lockPinOut,
    input wire        lockPinOe_n,
    input wire        vcoTapOut,
    input wire        distClkTick,
    input wire        clockOutputsOn,
    input wire        chipAwake,
    input wire        calBusy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    logic [3:0] awReg;
    logic [3:0] wSel;
    logic [3:0] selReg;
    logic [2:0] selAge;
    logic [7:0] calCnt;
    logic       bvQ;
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            awReg  <= 4'h0;
            wSel   <= 4'h0;
            selReg <= 4'h0;
            selAge <= 3'h0;
            calCnt <= 8'h00;
            bvQ    <= 1'b0;
        end
        else
        begin
            bvQ    <= s_axi_bvalid;
            calCnt <= calBusy ? calCnt + 8'h01 : 8'h00;
            if (s_axi_awvalid && s_axi_awready)
                awReg <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready)
                wSel <= s_axi_wdata[15:12];
            // age lets the pin flop catch up before any pin check
            if (s_axi_bvalid && !bvQ && awReg == 4'h0 && s_axi_bresp == 2'b00)
            begin
                selReg <= wSel;
                selAge <= 3'h0;
            end
            else if (selAge != 3'h7)
                selAge <= selAge + 3'h1;
        end
    end
    sequence fbWriteDone;
        s_axi_bvalid && s_axi_bready && awReg == 4'h4 && s_axi_bresp == 2'b00 && chipAwake;
    endsequence
    sequence selSettled;
        selAge > 3'h3 && chipAwake;
    endsequence
    a_sleep_all_off: assert property (!chipAwake |-> !clockOutputsOn && !vcoTapOut && !distClkTick)
        else $error("outputs active while asleep");
    a_gate_pin_off: assert property (!outputsGatePin |=> !clockOutputsOn)
        else $error("outputs on with gate pin low");
    a_tap_from_tick: assert property (vcoTapOut |-> $past(vcoTick))
        else $error("tap output without vco tick");
    a_cal_starts: assert property (fbWriteDone |-> ##[0:2] calBusy)
        else $error("feedback write did not start calibration");
    a_cal_length: assert property ($fell(calBusy) && chipAwake |-> calCnt == 8'h40)
        else $error("calibration length wrong");
    a_pin_hiz: assert property (selSettled ##0 selReg == 4'h0 |-> lockPinOe_n)
        else $error("pin driven with selector zero");
    a_pin_fixed: assert property (selSettled ##0 (selReg == 4'h1 || selReg == 4'h2)
        |-> !lockPinOe_n && lockPinOut == (selReg == 4'h1))
        else $error("fixed pin level wrong");
    a_lock_polarity: assert property (selSettled ##0 (selReg == 4'h3 || selReg == 4'h4) && !lockDetect
        && !$past(lockDetect) && !$past(lockDetect, 2) |-> !lockPinOe_n && lockPinOut == (selReg == 4'h4))
        else $error("lock pin polarity wrong");
    a_half_ref_tick: assert property (selSettled ##0 selReg == 4'hB && $changed(lockPinOut)
        |-> $past(oscTick) || $past(oscTick, 2) || $past(oscTick, 3))
        else $error("halved reference toggled without tick");
endmodule

bind pldc_top pldc_props u_props
(
    .clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .oscTick, .vcoTick, .lockDetect,
    .outputsGatePin, .lockPinOut, .lockPinOe_n, .vcoTapOut, .distClkTick, .clockOutputsOn,
    .chipAwake, .calBusy
);

// [dv/tb_top.sv]
// Purpose: self-checking bench for pldc_top
// Assumes: full-word writes, random tick strobes
// Notes: short divider ratios keep halved outputs quick
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, oscTick = 0, vcoTick = 0, lockDetect = 0;
    logic        outputsGatePin = 1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, lockPinOut, lockPinOe_n, vcoTapOut, distClkTick, clockOutputsOn;
    logic        chipAwake, calBusy, pv, ex;
    logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd, d;
    logic [31:0] regModel [0:1];
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    int          badCount = 0, testsRun = 0, cyc = 0, k, n, seed = 32'h9aaf_3826;
    pldc_top dut_u
    (
        .clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .oscTick, .vcoTick, .lockDetect, .outputsGatePin, .lockPinOut, .lockPinOe_n, .vcoTapOut,
        .distClkTick, .clockOutputsOn, .chipAwake, .calBusy
    );
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        oscTick <= $random(seed);
        vcoTick <= $random(seed);
        cyc++;
        if (cyc == 20000)
        begin
            badCount++;
            endSim();
        end
    end
    task automatic endSim();
    begin
        $display("checks %0d mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    begin
        testsRun++;
        if (seen !== exp)
        begin
            badCount++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    end
    endtask
    // model: only the two control words are writable, all else refused
    task automatic axiWrite(input logic [3:0] a, input logic [31:0] wd);
    begin
        s_axi_awaddr <= a;
        s_axi_wdata <= wd;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        check(s_axi_bresp, (a == 4'h0 || a == 4'h4) ? 2'b00 : 2'b10, "bresp");
        if (a == 4'h0 || a == 4'h4)
            regModel[a[2]] = wd;
        @(posedge clk_sys);
    end
    endtask
    task automatic axiRead(input logic [3:0] a);
    begin
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        @(posedge clk_sys);
    end
    endtask
    task automatic halfRun(input logic [3:0] code, input int per, input logic useOsc);
        int t;
        int tg;
        int dc;
        logic last;
    begin
        axiWrite(4'h0, 32'h0002_0002 | (code << 12));
        repeat (4) @(posedge clk_sys);
        t = 0;
        tg = 0;
        dc = 0;
        last = lockPinOut;
        repeat (120)
        begin
            @(posedge clk_sys);
            t += useOsc ? oscTick : vcoTick;
            dc += distClkTick;
            tg += (lockPinOut !== last);
            last = lockPinOut;
        end
        check((t / per - tg) inside {[-2:2]}, 1, "halfRate");
        if (!useOsc)
            check((t / 2 - dc) inside {[-2:2]}, 1, "postRate");
    end
    endtask
    initial
    begin
        regModel[0] = 32'h0002_000A;
        regModel[1] = 32'h0008_02F8;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        check(lockPinOe_n, 1, "pinOeRst");
        for (k = 0; k < 2; k++)
        begin
            axiRead(k * 4);
            check(rd, regModel[k], "regRst");
        end
        axiRead(4'hC);
        check(rsp, 2'b10, "rresp");
        axiWrite(4'hC, 32'h0000_0001);
        axiWrite(4'h0, 32'h0002_0002);
        // the dividers stay idle after reset until a feedback write starts calibration
        axiWrite(4'h4, 32'h0008_0003);
        @(posedge clk_sys);
        check(calBusy, 1, "calStart");
        n = 0;
        while (calBusy === 1'b1 && n < 200)
        begin
            @(posedge clk_sys);
            n++;
        end
        check(n inside {[58:64]}, 1, "calLen");
        // status: awake and running, calibration over, no lock seen yet
        axiRead(4'h8);
        check(rd, 32'h0000_0003, "status");
        for (k = 0; k < 5; k++)
        begin
            lockDetect <= $random(seed);
            axiWrite(4'h0, 32'h0002_0002 | (k << 12));
            repeat (3) @(posedge clk_sys);
            check(lockPinOe_n, k == 0, "pinOe");
            ex = (k == 1) | (k == 3 & lockDetect) | (k == 4 & !lockDetect);
            if (k != 0)
                check(lockPinOut, ex, "pinLevel");
        end
        halfRun(4'hB, 2, 1'b1);
        halfRun(4'h9, 6, 1'b0);
        axiWrite(4'h0, 32'h0006_0002);
        repeat (2) @(posedge clk_sys);
        pv = vcoTick;
        repeat (20)
        begin
            @(posedge clk_sys);
            check(vcoTapOut, pv, "tapCopy");
            pv = vcoTick;
        end
        for (k = 0; k < 4; k++)
        begin
            outputsGatePin <= k[0];
            axiWrite(4'h0, 32'h0004_0002 | (k[1] << 17));
            repeat (2) @(posedge clk_sys);
            check(clockOutputsOn, k[0] & k[1], "outGate");
        end
        axiWrite(4'h0, 32'h0007_0002);
        repeat (2) @(posedge clk_sys);
        check({chipAwake, clockOutputsOn, vcoTapOut}, 0, "sleepOff");
        d = {$random(seed)} % 4095 + 1;
        axiWrite(4'h0, 32'h0002_0000 | d);
        d = {$random(seed)} % 262143 + 1 + (({$random(seed)} % 7 + 2) << 18);
        axiWrite(4'h4, d);
        for (k = 0; k < 2; k++)
        begin
            axiRead(k * 4);
            check(rd, regModel[k], "regBack");
        end
        check(chipAwake, 1, "awake");
        endSim();
    end
endmodule
